/* File: design/pfs_consts.vh */
// Constants for the program flash self-programming sequencer.
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// Register offsets on the plain register port.
`define PFS_ADDR_PTR_LOW    3'h0
`define PFS_ADDR_PTR_HIGH   3'h1
`define PFS_ADDR_PTR_UPPER  3'h2
`define PFS_ADDR_LATCH      3'h3
`define PFS_ADDR_CTRL       3'h4
`define PFS_ADDR_UNLOCK     3'h5

// Control register field positions.
`define PFS_CTRL_PROG_SEL   7
`define PFS_CTRL_CFG_SEL    6
`define PFS_CTRL_ERASE_SEL  4
`define PFS_CTRL_PERMIT     2
`define PFS_CTRL_START      1

// Unlock key values.
`define PFS_KEY_FIRST       8'h55
`define PFS_KEY_SECOND      8'hAA

// Table pointer update modes.
`define PFS_MODE_KEEP       2'h0
`define PFS_MODE_POST_INC   2'h1
`define PFS_MODE_POST_DEC   2'h2
`define PFS_MODE_PRE_INC    2'h3

// Widths and reset values.
`define PFS_PTR_W           22
`define PFS_BLOCK_BYTES     64
`define PFS_HOLD_RESET      8'hFF
`define PFS_PTR_RESET       22'h000000
`define PFS_CTRL_RESET      8'h00

// Timing: long write duration and the clock rate.
`define PFS_LONG_WRITE_US   2000
`define PFS_CLK_KHZ         40000
`define PFS_LONG_WRITE_CYC  ((`PFS_LONG_WRITE_US * `PFS_CLK_KHZ) / 1000)
`define PFS_TIMER_W         17

`endif

/* File: design/pfs_nvm_seq.v */
// Program flash self-programming sequencer: table access, holding block, long writes.
//
// Operation
// - Plain table read/write leaves the program byte pointer unchanged.
// - Post-increment forms access at pointer, then add one.
// - Post-decrement forms access at pointer, then subtract one.
// - Pre-increment forms add one first, then access the new address.
// - Table read fetches one byte at the pointer into the table byte latch.
// - Pointer bit zero picks high or low byte of the word.
// - Erase clears one 64-byte block chosen by pointer bits 21:6.
// - No single-word erase; the block is the smallest erasable unit.
// - Start after valid unlock with erase selected erases; CPU stalls about 2 ms.
// - Execution halts during long cycles; the internal timer ends them.
// - Programming works only on whole 64-byte blocks.
// - Table writes only load the 64 holding registers, never flash.
// - Block programming needs program write selected then unlock and start.
// - Holding registers become FFh on reset and after each program.
// - Holding bytes left at FFh leave flash bytes unchanged.
// - Table read uses all 22 pointer bits for the address.
// - Automatic pointer updates touch only the low 21 bits.
// - Program writes the whole holding block at the upper pointer bits.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.vh"

module pfs_nvm_seq #(
   parameter [`PFS_TIMER_W-1:0] LONG_WRITE_CYC = `PFS_LONG_WRITE_CYC
) (
   // Clock and reset.
   input  wire         clk,
   input  wire         sys_rst,
   // Register port.
   input  wire [2:0]   reg_addr,
   input  wire [7:0]   reg_wdata,
   input  wire         reg_we,
   input  wire         reg_re,
   output reg  [7:0]   reg_rdata,
   // Table instruction port from the core.
   input  wire         tbl_req,
   input  wire         tbl_write,
   input  wire [1:0]   tbl_mode,
   output reg          tbl_done,
   // Core stall.
   output wire         cpu_stall,
   // Flash array read port.
   output reg          flash_rd_en,
   output reg  [20:0]  flash_rd_word,
   output reg          flash_rd_cfg,
   input  wire [15:0]  flash_rd_data,
   // Flash array erase and program port.
   output reg          flash_erase,
   output reg          flash_prog,
   output reg  [15:0]  flash_blk_addr,
   output wire [511:0] flash_prog_data
);

   localparam S_IDLE = 2'b01;
   localparam S_BUSY = 2'b10;

   reg  [1:0]                state_q;
   reg  [`PFS_PTR_W-1:0]     ptr_q;
   reg  [7:0]                latch_q;
   reg                       prog_sel_q;
   reg                       cfg_sel_q;
   reg                       erase_sel_q;
   reg                       permit_q;
   reg                       start_q;
   reg  [1:0]                unlock_q;
   reg                       op_erase_q;
   reg  [`PFS_TIMER_W-1:0]   timer_q;
   reg                       rd_pend_q;
   reg                       rd_hi_q;
   reg  [7:0]                hold_q [0:`PFS_BLOCK_BYTES-1];

   reg  [`PFS_PTR_W-1:0]     acc_addr;
   reg  [20:0]               ptr_low_d;
   reg  [7:0]                ctrl_view;
   wire                      tbl_go;
   wire                      start_wr;
   wire                      start_ok;
   wire                      cycle_end;
   integer                   i;

   // Table instructions are ignored while a long cycle holds the core.
   assign tbl_go    = tbl_req & (state_q == S_IDLE);
   assign cpu_stall = (state_q == S_BUSY);
   assign cycle_end = (state_q == S_BUSY) & (timer_q == {`PFS_TIMER_W{1'b0}});

   assign start_wr = reg_we & (reg_addr == `PFS_ADDR_CTRL) & reg_wdata[`PFS_CTRL_START];
   // The keys must be the very last two register writes before the start write.
   assign start_ok = start_wr & (state_q == S_IDLE) & (unlock_q == 2'd2)
                   & reg_wdata[`PFS_CTRL_PERMIT]
                   & reg_wdata[`PFS_CTRL_PROG_SEL]
                   & ~reg_wdata[`PFS_CTRL_CFG_SEL];

   genvar g;
   generate
      for (g = 0; g < `PFS_BLOCK_BYTES; g = g + 1) begin : g_hold
         assign flash_prog_data[8*g+7:8*g] = hold_q[g];
      end
   endgenerate

   // Access address and the pointer's next low bits for each table form.
   always @* begin
      acc_addr  = ptr_q;
      ptr_low_d = ptr_q[20:0];
      case (tbl_mode)
         `PFS_MODE_KEEP: begin
            ptr_low_d = ptr_q[20:0];
         end
         `PFS_MODE_POST_INC: begin
            ptr_low_d = ptr_q[20:0] + 21'h000001;
         end
         `PFS_MODE_POST_DEC: begin
            ptr_low_d = ptr_q[20:0] - 21'h000001;
         end
         `PFS_MODE_PRE_INC: begin
            ptr_low_d = ptr_q[20:0] + 21'h000001;
            acc_addr  = {ptr_q[21], ptr_low_d};
         end
         default: begin
            ptr_low_d = ptr_q[20:0];
         end
      endcase
   end

   always @* begin
      ctrl_view = 8'h00;
      ctrl_view[`PFS_CTRL_PROG_SEL]  = prog_sel_q;
      ctrl_view[`PFS_CTRL_CFG_SEL]   = cfg_sel_q;
      ctrl_view[`PFS_CTRL_ERASE_SEL] = erase_sel_q;
      ctrl_view[`PFS_CTRL_PERMIT]    = permit_q;
      ctrl_view[`PFS_CTRL_START]     = start_q;
   end

   // Pointer: software writes bytes, table forms update only the low 21 bits.
   always @(posedge clk) begin
      if (sys_rst) begin
         ptr_q <= `PFS_PTR_RESET;
      end else if (tbl_go) begin
         ptr_q <= {ptr_q[21], ptr_low_d};
      end else if (reg_we) begin
         case (reg_addr)
            `PFS_ADDR_PTR_LOW:   ptr_q[7:0]   <= reg_wdata;
            `PFS_ADDR_PTR_HIGH:  ptr_q[15:8]  <= reg_wdata;
            `PFS_ADDR_PTR_UPPER: ptr_q[21:16] <= reg_wdata[5:0];
            default:             ptr_q        <= ptr_q;
         endcase
      end
   end

   // Flash read request; data are taken at the edge that ends the request cycle.
   always @(posedge clk) begin
      if (sys_rst) begin
         flash_rd_en   <= 1'b0;
         flash_rd_word <= 21'h000000;
         flash_rd_cfg  <= 1'b0;
         rd_pend_q     <= 1'b0;
         rd_hi_q       <= 1'b0;
      end else begin
         flash_rd_en <= tbl_go & ~tbl_write;
         rd_pend_q   <= tbl_go & ~tbl_write;
         if (tbl_go & ~tbl_write) begin
            flash_rd_cfg  <= acc_addr[21];
            flash_rd_word <= {1'b0, acc_addr[20:1]};
            rd_hi_q       <= acc_addr[0];
         end
      end
   end

   // Table byte latch and completion pulse of a table instruction.
   always @(posedge clk) begin
      if (sys_rst) begin
         latch_q  <= 8'h00;
         tbl_done <= 1'b0;
      end else begin
         tbl_done <= (tbl_go & tbl_write) | rd_pend_q;
         if (rd_pend_q) begin
            latch_q <= rd_hi_q ? flash_rd_data[15:8] : flash_rd_data[7:0];
         end else if (reg_we & (reg_addr == `PFS_ADDR_LATCH)) begin
            latch_q <= reg_wdata;
         end
      end
   end

   // Holding block: loaded only by table writes, preset after reset and program.
   always @(posedge clk) begin
      if (sys_rst) begin
         for (i = 0; i < `PFS_BLOCK_BYTES; i = i + 1) begin
            hold_q[i] <= `PFS_HOLD_RESET;
         end
      end else if (cycle_end & ~op_erase_q) begin
         for (i = 0; i < `PFS_BLOCK_BYTES; i = i + 1) begin
            hold_q[i] <= `PFS_HOLD_RESET;
         end
      end else if (tbl_go & tbl_write) begin
         hold_q[acc_addr[5:0]] <= latch_q;
      end
   end

   // Unlock tracker: any register write that breaks the key order disarms it.
   always @(posedge clk) begin
      if (sys_rst) begin
         unlock_q <= 2'd0;
      end else if (reg_we) begin
         if ((reg_addr == `PFS_ADDR_UNLOCK) & (reg_wdata == `PFS_KEY_FIRST)) begin
            unlock_q <= 2'd1;
         end else if ((reg_addr == `PFS_ADDR_UNLOCK) & (reg_wdata == `PFS_KEY_SECOND)
                      & (unlock_q == 2'd1)) begin
            unlock_q <= 2'd2;
         end else begin
            unlock_q <= 2'd0;
         end
      end
   end

   // Control register bits.
   always @(posedge clk) begin
      if (sys_rst) begin
         prog_sel_q  <= 1'b0;
         cfg_sel_q   <= 1'b0;
         erase_sel_q <= 1'b0;
         permit_q    <= 1'b0;
      end else if (reg_we & (reg_addr == `PFS_ADDR_CTRL)) begin
         prog_sel_q  <= reg_wdata[`PFS_CTRL_PROG_SEL];
         cfg_sel_q   <= reg_wdata[`PFS_CTRL_CFG_SEL];
         erase_sel_q <= reg_wdata[`PFS_CTRL_ERASE_SEL];
         permit_q    <= reg_wdata[`PFS_CTRL_PERMIT];
      end
   end

   // Long write sequencer: one erase or program of a whole block per start.
   always @(posedge clk) begin
      if (sys_rst) begin
         state_q        <= S_IDLE;
         start_q        <= 1'b0;
         op_erase_q     <= 1'b0;
         timer_q        <= {`PFS_TIMER_W{1'b0}};
         flash_erase    <= 1'b0;
         flash_prog     <= 1'b0;
         flash_blk_addr <= 16'h0000;
      end else begin
         flash_erase <= 1'b0;
         flash_prog  <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start_ok) begin
                  state_q        <= S_BUSY;
                  start_q        <= 1'b1;
                  op_erase_q     <= reg_wdata[`PFS_CTRL_ERASE_SEL];
                  flash_erase    <= reg_wdata[`PFS_CTRL_ERASE_SEL];
                  flash_prog     <= ~reg_wdata[`PFS_CTRL_ERASE_SEL];
                  flash_blk_addr <= ptr_q[21:6];
                  timer_q        <= LONG_WRITE_CYC - {{(`PFS_TIMER_W-1){1'b0}}, 1'b1};
               end
            end
            S_BUSY: begin
               if (cycle_end) begin
                  state_q <= S_IDLE;
                  start_q <= 1'b0;
               end else begin
                  timer_q <= timer_q - {{(`PFS_TIMER_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               state_q <= S_IDLE;
               start_q <= 1'b0;
            end
         endcase
      end
   end

   // Register read data, one cycle after the read strobe.
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         case (reg_addr)
            `PFS_ADDR_PTR_LOW:   reg_rdata <= ptr_q[7:0];
            `PFS_ADDR_PTR_HIGH:  reg_rdata <= ptr_q[15:8];
            `PFS_ADDR_PTR_UPPER: reg_rdata <= {2'b00, ptr_q[21:16]};
            `PFS_ADDR_LATCH:     reg_rdata <= latch_q;
            `PFS_ADDR_CTRL:      reg_rdata <= ctrl_view;
            default:             reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

`default_nettype wire

/* File: verification/pfs_flash_model.sv */
// Flash array read model facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module pfs_flash_model (
   input wire logic         clk,
   input wire logic         flash_rd_en,
   input wire logic [20:0]  flash_rd_word,
   input wire logic         flash_rd_cfg,
   output var logic [15:0]  flash_rd_data
);
   logic [7:0] x;
   assign x = {flash_rd_cfg, 7'h00};
   // The word answers in the cycle of the read request, as the sequencer latches it
   // at the edge that ends that cycle. Outside it the data are inverted, so a late
   // or early capture cannot pass.
   always_comb begin
      if (flash_rd_en) begin
         flash_rd_data = {flash_rd_word[7:0] ^ x, flash_rd_word[15:8] ^ x};
      end else begin
         flash_rd_data = ~{flash_rd_word[7:0] ^ x, flash_rd_word[15:8] ^ x};
      end
   end
endmodule
`default_nettype wire

/* File: verification/pfs_nvm_seq_asserts.sv */
// Checker for the self-programming sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module pfs_nvm_seq_asserts #(
   parameter [16:0] LONG_WRITE_CYC = 17'h13880
) (
   // Clock and reset.
   input wire logic         clk,
   input wire logic         sys_rst,
   // Register and table ports.
   input wire logic [2:0]   reg_addr,
   input wire logic [7:0]   reg_wdata,
   input wire logic         reg_we,
   input wire logic         tbl_req,
   input wire logic         tbl_write,
   input wire logic         tbl_done,
   // Core stall and flash ports.
   input wire logic         cpu_stall,
   input wire logic         flash_rd_en,
   input wire logic         flash_erase,
   input wire logic         flash_prog,
   input wire logic [511:0] flash_prog_data
);
   logic [16:0] stall_cnt_q;
   logic        was_prog_q;
   logic [1:0]  arm_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   always @(posedge clk) begin
      if (sys_rst) begin
         stall_cnt_q <= 17'h00000;
         was_prog_q  <= 1'b0;
         arm_q       <= 2'h0;
      end else begin
         // Idle cycles and reads keep the keys armed; any other write drops them.
         if (reg_we) begin
            arm_q <= (reg_addr == 3'h5 && reg_wdata == 8'h55) ? 2'h1 :
                     (reg_addr == 3'h5 && reg_wdata == 8'hAA && arm_q == 2'h1) ? 2'h2 : 2'h0;
         end
         stall_cnt_q <= cpu_stall ? stall_cnt_q + 17'h00001 : 17'h00000;
         if (flash_prog || flash_erase) begin
            was_prog_q <= flash_prog;
         end
      end
   end
   chk_read_fetch: assert property (tbl_req && !tbl_write && !cpu_stall
      |=> flash_rd_en ##1 tbl_done) else $error("table read did not fetch");
   chk_write_only_hold: assert property (tbl_req && tbl_write && !cpu_stall
      |=> tbl_done && !flash_rd_en && !flash_prog && !flash_erase)
      else $error("table write misbehaved");
   chk_stall_length: assert property ($fell(cpu_stall)
      |-> stall_cnt_q == LONG_WRITE_CYC) else $error("stall length wrong");
   chk_start_pulse: assert property ($rose(cpu_stall) |-> (flash_erase ^ flash_prog)
      ##1 !(flash_erase || flash_prog)) else $error("start pulse wrong");
   chk_unlock_order: assert property ((flash_erase || flash_prog) |->
      $past(reg_we && reg_addr == 3'h4 && reg_wdata[2] && reg_wdata[1] && arm_q == 2'h2))
      else $error("cycle started without unlock");
   chk_hold_refill: assert property ($fell(cpu_stall) && was_prog_q
      |-> ##[0:2] (&flash_prog_data)) else $error("holding block not refilled");
   chk_reset_state: assert property ($fell(sys_rst)
      |-> !cpu_stall && (&flash_prog_data)) else $error("reset state wrong");
   chk_stall_drops: assert property (cpu_stall && tbl_req
      |=> !tbl_done && !flash_rd_en) else $error("request taken while stalled");
endmodule
bind pfs_nvm_seq pfs_nvm_seq_asserts #(.LONG_WRITE_CYC(LONG_WRITE_CYC)) i_chk (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_we(reg_we), .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_done(tbl_done),
   .cpu_stall(cpu_stall), .flash_rd_en(flash_rd_en), .flash_erase(flash_erase),
   .flash_prog(flash_prog), .flash_prog_data(flash_prog_data));
`default_nettype wire

/* File: verification/pfs_nvm_seq_tb.sv */
// Self-checking bench for the self-programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module pfs_nvm_seq_tb;
   logic clk = 0, sys_rst = 1, reg_we = 0, reg_re = 0, tbl_req = 0, tbl_write = 0;
   logic [2:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, b;
   logic [1:0] tbl_mode = 0, m;
   logic tbl_done, cpu_stall, flash_rd_en, flash_rd_cfg, flash_erase, flash_prog;
   logic [20:0] flash_rd_word;
   logic [15:0] flash_rd_data, flash_blk_addr;
   logic [511:0] flash_prog_data;
   logic [21:0] p, ra, pa, q;
   logic [67:0] rows [4];
   int fails = 0, checked = 0, cyc = 0, i;
   pfs_nvm_seq #(.LONG_WRITE_CYC(17'h00014)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .tbl_req(tbl_req), .tbl_write(tbl_write),
      .tbl_mode(tbl_mode), .tbl_done(tbl_done), .cpu_stall(cpu_stall),
      .flash_rd_en(flash_rd_en), .flash_rd_word(flash_rd_word),
      .flash_rd_cfg(flash_rd_cfg), .flash_rd_data(flash_rd_data),
      .flash_erase(flash_erase), .flash_prog(flash_prog),
      .flash_blk_addr(flash_blk_addr), .flash_prog_data(flash_prog_data));
   pfs_flash_model i_flash (.clk(clk), .flash_rd_en(flash_rd_en),
      .flash_rd_word(flash_rd_word), .flash_rd_cfg(flash_rd_cfg),
      .flash_rd_data(flash_rd_data));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task give_verdict;
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         give_verdict;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked = checked + 1;
      if (s !== e) begin
         fails = fails + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk); reg_we <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk); reg_we <= 0;
   endtask
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk); reg_re <= 1; reg_addr <= a;
      @(posedge clk); reg_re <= 0;
      @(negedge clk); d = reg_rdata;
   endtask
   task setp(input logic [21:0] v);
      wr(3'h0, v[7:0]); wr(3'h1, v[15:8]); wr(3'h2, {2'h0, v[21:16]});
   endtask
   task rdp(output logic [21:0] v);
      logic [7:0] b0, b1, b2;
      rd(3'h0, b0); rd(3'h1, b1); rd(3'h2, b2);
      v = {b2[5:0], b1, b0};
   endtask
   task tbl(input logic w, input logic [1:0] md);
      @(posedge clk); tbl_req <= 1; tbl_write <= w; tbl_mode <= md;
      @(posedge clk); tbl_req <= 0;
      if (!w) @(posedge clk);
      @(negedge clk); chk(tbl_done, 1);
   endtask
   task unlock(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
      wr(3'h5, k1); wr(3'h5, k2); wr(3'h4, c);
   endtask
   task wait_idle;
      for (int n = 0; n < 100 && cpu_stall; n++) @(negedge clk);
      chk(cpu_stall, 0);
   endtask
   function logic [7:0] exp_byte(input logic [21:0] a);
      logic [7:0] x;
      x = {a[21], 7'h00};
      return a[0] ? a[8:1] ^ x : a[16:9] ^ x;
   endfunction
   initial begin
      rows[0] = {2'h0, 22'h000123, 22'h000123, 22'h000123};
      rows[1] = {2'h1, 22'h1FFFFF, 22'h1FFFFF, 22'h000000};
      rows[2] = {2'h2, 22'h200000, 22'h200000, 22'h3FFFFF};
      rows[3] = {2'h3, 22'h000456, 22'h000457, 22'h000457};
      repeat (8) @(posedge clk);
      sys_rst <= 0;
      @(negedge clk); chk(&flash_prog_data, 1);
      for (i = 0; i < 4; i++) begin
         {m, p, ra, pa} = rows[i];
         setp(p); tbl(0, m);
         rd(3'h3, b); chk(b, exp_byte(ra));
         rdp(q); chk(q, pa);
      end
      rd(3'h7, b); chk(b, 8'h00);
      unlock(8'h55, 8'h55, 8'h86);
      @(negedge clk); chk(cpu_stall, 0);
      unlock(8'h55, 8'hAA, 8'h82);
      @(negedge clk); chk(cpu_stall, 0);
      setp(22'h0012BF); unlock(8'h55, 8'hAA, 8'h96);
      @(negedge clk); chk({cpu_stall, flash_erase, flash_blk_addr}, {2'b11, 16'h004A});
      @(posedge clk); tbl_req <= 1; tbl_write <= 0;
      @(posedge clk); tbl_req <= 0;
      repeat (2) begin
         @(negedge clk); chk(tbl_done, 0);
      end
      rd(3'h4, b); chk(b[1], 1);
      wait_idle;
      rd(3'h4, b); chk(b[1], 0);
      wr(3'h3, 8'h3C); setp(22'h0000C5); tbl(1, 2'h1);
      rdp(q); chk(q, 22'h0000C6);
      chk(flash_prog_data[47:40], 8'h3C);
      unlock(8'h55, 8'hAA, 8'h86);
      @(negedge clk); chk({cpu_stall, flash_prog, flash_blk_addr}, {2'b11, 16'h0003});
      chk(&{flash_prog_data[511:48], flash_prog_data[39:0]}, 1);
      wait_idle;
      repeat (2) @(negedge clk);
      chk(&flash_prog_data, 1);
      // A reset in mid-run must drop a half-loaded holding block back to all ones.
      wr(3'h3, 8'h5A); tbl(1, 2'h0);
      chk(flash_prog_data[55:48], 8'h5A);
      @(posedge clk); sys_rst <= 1;
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      @(negedge clk); chk(&flash_prog_data, 1);
      give_verdict;
   end
endmodule
`default_nettype wire
